// ==== hdl/asc_top.sv ====
// Converter sequence control with AXI4-Lite registers and result buffer.
`timescale 1ns/1ps
`default_nettype none
module asc_top (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [asc_pkg::ASC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [asc_pkg::ASC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic idleMode,
    input wire logic timerCompareEvent,
    input wire logic externalInterruptPin,
    input wire logic convDone,
    input wire logic [asc_pkg::ASC_RES_W-1:0] convResult,
    output logic converterOn,
    output logic sampleHold,
    output logic convStart,
    output logic convClkTick,
    output logic refPosExternal,
    output logic refNegExternal,
    output logic [3:0] chanPos,
    output logic chanNegAlt,
    output logic irq
);
    import asc_pkg::*;

    // Merge a bus write into the low half-word of a register.
    function automatic logic [15:0] mergeWrite(input logic [15:0] old, input logic [31:0] d,
                                               input logic [3:0] s, input logic [15:0] m);
        logic [15:0] v;
        v = old;
        if (s[0]) begin
            v[7:0] = d[7:0];
        end
        if (s[1]) begin
            v[15:8] = d[15:8];
        end
        return v & m;
    endfunction

    // Next scan channel after cur whose select bit is set; stays put if none.
    function automatic logic [3:0] nextScan(input logic [3:0] cur, input logic [15:0] m);
        logic [3:0] c;
        logic found;
        c = cur;
        found = 1'b0;
        for (int i = 1; i <= ASC_BUF_DEPTH; i++) begin
            if (!found && m[4'(cur + 4'(i))]) begin
                c = 4'(cur + 4'(i));
                found = 1'b1;
            end
        end
        return c;
    endfunction

    // Present a raw result in one of the four layouts.
    function automatic logic [15:0] formatResult(input logic [9:0] r, input logic [1:0] f);
        logic [15:0] v;
        unique case (f)
            ASC_FMT_INT: v = {6'h00, r};
            ASC_FMT_SINT: v = {{6{~r[9]}}, ~r[9], r[8:0]};
            ASC_FMT_FRAC: v = {r, 6'h00};
            ASC_FMT_SFRAC: v = {~r[9], r[8:0], 6'h00};
        endcase
        return v;
    endfunction

    logic awHeld;
    logic wHeld;
    logic [ASC_ADDR_W-1:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [15:0] ctrl1;
    logic [15:0] ctrl2;
    logic [15:0] ctrl3;
    logic [15:0] chSel;
    logic [15:0] scanSel;
    logic [ASC_IRQ_W-1:0] irqStatus;
    logic [ASC_IRQ_W-1:0] irqMask;
    logic doneBit;
    logic bufFill;
    logic [3:0] bufPtr;
    logic [3:0] seqCount;
    logic [3:0] scanChan;
    logic useMuxB;
    logic [7:0] tadCount;
    logic [4:0] sampleCount;
    logic extPrev;
    asc_state_e state;
    logic [15:0] resultBuf [ASC_BUF_DEPTH];

    // Write path: address and data are latched separately, in either order.
    wire wrFire = awHeld && wHeld && !s_axi_bvalid;
    wire [7:0] wrAddr = awAddr;
    wire wrCtrl1 = wrFire && wrAddr == ASC_OFF_CTRL1;
    wire wrCtrl2 = wrFire && wrAddr == ASC_OFF_CTRL2;
    wire wrCtrl3 = wrFire && wrAddr == ASC_OFF_CTRL3;
    wire wrChSel = wrFire && wrAddr == ASC_OFF_CHSEL;
    wire wrScan = wrFire && wrAddr == ASC_OFF_SCAN;
    wire wrIrqSt = wrFire && wrAddr == ASC_OFF_IRQST;
    wire wrIrqMsk = wrFire && wrAddr == ASC_OFF_IRQMSK;
    wire wrHit = wrCtrl1 || wrCtrl2 || wrCtrl3 || wrChSel || wrScan || wrIrqSt || wrIrqMsk;
    wire wrCtrl1Lo = wrCtrl1 && wStrb[0];

    // Field views of the control registers.
    wire moduleOn = ctrl1[ASC_B_ON];
    wire idleStop = ctrl1[ASC_B_IDLE];
    wire [1:0] resultFormat = ctrl1[ASC_B_FORM +: 2];
    wire [2:0] triggerSource = ctrl1[ASC_B_SRC +: 3];
    wire autoSampleStart = ctrl1[ASC_B_AUTO_SAMPLE_START];
    wire [2:0] referenceSelect = ctrl2[ASC_B_VCFG +: 3];
    wire scanEnable = ctrl2[ASC_B_SCAN];
    wire [3:0] interruptRate = ctrl2[ASC_B_RATE +: 4];
    wire bufferMode = ctrl2[ASC_B_BUFFER_MODE];
    wire alternateSampleMode = ctrl2[ASC_B_ALTERNATE_SAMPLE_MODE];
    wire [4:0] autoSampleCount = ctrl3[ASC_B_SAMC +: 5];
    wire [7:0] conversionClockSelect = ctrl3[ASC_B_ADCS +: 8];

    // Off clears the sequence; idle-stop only freezes it so it resumes in place.
    wire halted = idleStop && idleMode;
    wire running = moduleOn && !halted;
    // Off forces the sampling bit low at once, ahead of the state register.
    wire samplingBit = moduleOn && state == ASC_ST_SAMPLE;
    // Sampling writes use the held word; the bus may have moved on.
    wire swSetSamp = wrCtrl1Lo && wData[ASC_B_SAMPLING_BIT];
    wire swClrSamp = wrCtrl1Lo && !wData[ASC_B_SAMPLING_BIT];

    // Conversion clock: one tick every select+1 system cycles.
    wire tadTick = running && tadCount >= conversionClockSelect;
    wire extRise = externalInterruptPin && !extPrev;
    wire autoEnd = sampleCount >= autoSampleCount;

    // Trigger that ends sampling; reserved codes never end it by hardware.
    wire endTrigger = (triggerSource == ASC_TRIG_AUTO) ? autoEnd :
                      (triggerSource == ASC_TRIG_TIMER) ? timerCompareEvent :
                      (triggerSource == ASC_TRIG_EXT) ? extRise :
                      (triggerSource == ASC_TRIG_MANUAL) ? swClrSamp : 1'b0;
    wire startConv = running && samplingBit && endTrigger;
    wire abortSample = running && samplingBit && !endTrigger && swClrSamp;
    wire startSample = running && state == ASC_ST_HOLD && (autoSampleStart || swSetSamp);
    wire finishConv = running && state == ASC_ST_CONVERT && convDone;
    wire rateHit = finishConv && seqCount == interruptRate;

    // Next state of the sample/convert sequence.
    wire asc_state_e next_state = !moduleOn ? ASC_ST_HOLD :
                                  startSample ? ASC_ST_SAMPLE :
                                  startConv ? ASC_ST_CONVERT :
                                  abortSample ? ASC_ST_HOLD :
                                  finishConv ? (autoSampleStart ? ASC_ST_SAMPLE : ASC_ST_HOLD)
                                  : state;

    // Buffer pointer steps within the active half in split mode.
    wire splitMode = bufferMode;
    wire next_bufFill = splitMode ? ~bufFill : 1'b0;
    wire [3:0] stepPtr = splitMode ? {bufPtr[3], 3'(bufPtr[2:0] + 3'h1)} : 4'(bufPtr + 4'h1);
    wire [3:0] next_bufPtr = rateHit ? (next_bufFill ? ASC_HALF_B : 4'h0) : stepPtr;
    wire [3:0] firstScan = nextScan(4'hf, scanSel);

    // Channel presented to the sample/hold.
    wire [3:0] posA = scanEnable ? scanChan : chSel[ASC_B_POSA +: 4];
    assign chanPos = useMuxB ? chSel[ASC_B_POSB +: 4] : posA;
    assign chanNegAlt = useMuxB ? chSel[ASC_B_NEGB] : chSel[ASC_B_NEGA];
    assign refPosExternal = !referenceSelect[2] && referenceSelect[0];
    assign refNegExternal = !referenceSelect[2] && referenceSelect[1];
    assign converterOn = moduleOn;
    assign sampleHold = samplingBit;
    assign convStart = startConv;
    assign convClkTick = tadTick;

    // Read decode.
    wire [7:0] rdAddr = s_axi_araddr;
    wire rdBuf = rdAddr[7:6] == ASC_BUF_PAGE;
    wire [15:0] ctrl1View = {ctrl1[15:2], samplingBit, doneBit};
    wire [15:0] ctrl2View = {ctrl2[15:8], bufFill, ctrl2[6:0]};
    wire [15:0] rdWord = rdBuf ? resultBuf[rdAddr[5:2]] :
                         rdAddr == ASC_OFF_CTRL1 ? ctrl1View :
                         rdAddr == ASC_OFF_CTRL2 ? ctrl2View :
                         rdAddr == ASC_OFF_CTRL3 ? ctrl3 :
                         rdAddr == ASC_OFF_CHSEL ? chSel :
                         rdAddr == ASC_OFF_SCAN ? scanSel :
                         rdAddr == ASC_OFF_IRQST ? 16'(irqStatus) :
                         rdAddr == ASC_OFF_IRQMSK ? 16'(irqMask) : 16'h0000;
    wire rdHit = rdBuf || rdAddr == ASC_OFF_CTRL1 || rdAddr == ASC_OFF_CTRL2 ||
                 rdAddr == ASC_OFF_CTRL3 || rdAddr == ASC_OFF_CHSEL || rdAddr == ASC_OFF_SCAN ||
                 rdAddr == ASC_OFF_IRQST || rdAddr == ASC_OFF_IRQMSK;

    // Ready is low while a channel's item is held, so at most one write is open.
    assign s_axi_awready = !awHeld;
    assign s_axi_wready = !wHeld;
    assign s_axi_arready = !s_axi_rvalid;

    // Interrupt events; a hardware set wins over a write-one-to-clear.
    wire [ASC_IRQ_W-1:0] irqEvents = {finishConv, rateHit};
    wire [ASC_IRQ_W-1:0] irqClear = wrIrqSt && wStrb[0] ? wData[ASC_IRQ_W-1:0] : '0;
    assign irq = |(irqStatus & irqMask);

    // Write channel capture.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= '0;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
        end else begin
            if (s_axi_awvalid && !awHeld) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end else if (wrFire) begin
                awHeld <= 1'b0;
            end
            if (s_axi_wvalid && !wHeld) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end else if (wrFire) begin
                wHeld <= 1'b0;
            end
        end
    end

    // Write and read responses.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ASC_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= ASC_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            if (wrFire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrHit ? ASC_RESP_OKAY : ASC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {16'h0000, rdWord};
                s_axi_rresp <= rdHit ? ASC_RESP_OKAY : ASC_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Software-owned control registers.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ctrl1 <= 16'h0000;
            ctrl2 <= 16'h0000;
            ctrl3 <= 16'h0000;
            chSel <= 16'h0000;
            scanSel <= 16'h0000;
            irqMask <= '0;
        end else begin
            if (wrCtrl1) begin
                ctrl1 <= mergeWrite(ctrl1, wData, wStrb, ASC_MASK_CTRL1);
            end
            if (wrCtrl2) begin
                ctrl2 <= mergeWrite(ctrl2, wData, wStrb, ASC_MASK_CTRL2);
            end
            if (wrCtrl3) begin
                ctrl3 <= mergeWrite(ctrl3, wData, wStrb, ASC_MASK_CTRL3);
            end
            if (wrChSel) begin
                chSel <= mergeWrite(chSel, wData, wStrb, ASC_MASK_CHSEL);
            end
            if (wrScan) begin
                scanSel <= mergeWrite(scanSel, wData, wStrb, ASC_MASK_SCAN);
            end
            if (wrIrqMsk && wStrb[0]) begin
                irqMask <= wData[ASC_IRQ_W-1:0];
            end
        end
    end

    // Sticky status and done bit; the hardware set takes priority over a write so it wins.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            irqStatus <= '0;
            doneBit <= 1'b0;
        end else begin
            irqStatus <= (irqStatus & ~irqClear) | irqEvents;
            if (finishConv) begin
                doneBit <= 1'b1;
            end else if (startConv) begin
                doneBit <= 1'b0;
            end else if (wrCtrl1Lo) begin
                doneBit <= wData[ASC_B_DONE];
            end
        end
    end

    // Timing counters for the conversion clock and the automatic sample time.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            tadCount <= 8'h00;
            sampleCount <= 5'h00;
            extPrev <= 1'b0;
        end else begin
            extPrev <= externalInterruptPin;
            if (!moduleOn || tadTick) begin
                tadCount <= 8'h00;
            end else if (running) begin
                tadCount <= 8'(tadCount + 8'h01);
            end
            if (!samplingBit || !moduleOn) begin
                sampleCount <= 5'h00;
            end else if (tadTick && !autoEnd) begin
                sampleCount <= 5'(sampleCount + 5'h01);
            end
        end
    end

    // Sequence state, buffer filling and multiplexer stepping.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state <= ASC_ST_HOLD;
            bufPtr <= 4'h0;
            bufFill <= 1'b0;
            seqCount <= 4'h0;
            scanChan <= 4'h0;
            useMuxB <= 1'b0;
        end else begin
            state <= next_state;
            if (!moduleOn) begin
                bufPtr <= 4'h0;
                bufFill <= 1'b0;
                seqCount <= 4'h0;
                scanChan <= firstScan;
                useMuxB <= 1'b0;
            end else if (finishConv) begin
                bufPtr <= next_bufPtr;
                seqCount <= rateHit ? 4'h0 : 4'(seqCount + 4'h1);
                if (rateHit) begin
                    bufFill <= next_bufFill;
                end
                if (rateHit) begin
                    scanChan <= firstScan;
                end else if (!useMuxB) begin
                    scanChan <= nextScan(scanChan, scanSel);
                end
                useMuxB <= alternateSampleMode && !rateHit && !useMuxB;
            end
        end
    end

    // Result buffer store in the selected format.
    always_ff @(posedge sys_clk) begin
        if (finishConv) begin
            resultBuf[bufPtr] <= formatResult(convResult, resultFormat);
        end
    end
endmodule
`default_nettype wire

// ==== include/asc_pkg.sv ====
// Constants, register map and types for the converter sequence control block.
// Functional notes
// - Module-on bit enables the whole converter.
// - Idle-stop bit freezes converter during Idle.
// - Format field justifies and sign-extends results.
// - Code 111 uses internal sample counter.
// - Codes 010, 001, 000 select trigger.
// - Auto-start restarts sampling after each conversion.
// - Sampling bit shows sample/hold; both may change.
// - Done bit set on completion, hardware cleared.
// - Reference field selects positive and negative references.
// - Scan enable steps multiplexer A positive input.
// - Fill status shows which half converter fills.
// - Interrupt every (N+1)th sample/convert sequence.
// - Buffer mode splits buffer into halves.
// - Alternate mode swaps multiplexer B and A.
// - Conversion clock period is (select+1) cycles.
// - Auto sample time counts conversion clock periods.
package asc_pkg;
    localparam int ASC_ADDR_W = 8;
    localparam int ASC_RES_W = 10;
    localparam int ASC_BUF_DEPTH = 16;

    // Register byte offsets.
    localparam logic [7:0] ASC_OFF_CTRL1 = 8'h00;
    localparam logic [7:0] ASC_OFF_CTRL2 = 8'h04;
    localparam logic [7:0] ASC_OFF_CTRL3 = 8'h08;
    localparam logic [7:0] ASC_OFF_CHSEL = 8'h0c;
    localparam logic [7:0] ASC_OFF_SCAN = 8'h10;
    localparam logic [7:0] ASC_OFF_IRQST = 8'h14;
    localparam logic [7:0] ASC_OFF_IRQMSK = 8'h18;
    localparam logic [1:0] ASC_BUF_PAGE = 2'h1;

    // Writable bit masks; everything else reads as zero except the sampling, done and fill status bits.
    localparam logic [15:0] ASC_MASK_CTRL1 = 16'ha3e4;
    localparam logic [15:0] ASC_MASK_CTRL2 = 16'he43f;
    localparam logic [15:0] ASC_MASK_CTRL3 = 16'h9fff;
    localparam logic [15:0] ASC_MASK_CHSEL = 16'h8f8f;
    localparam logic [15:0] ASC_MASK_SCAN = 16'h9fff;

    // Primary control fields.
    localparam int ASC_B_ON = 15;
    localparam int ASC_B_IDLE = 13;
    localparam int ASC_B_FORM = 8;
    localparam int ASC_B_SRC = 5;
    localparam int ASC_B_AUTO_SAMPLE_START = 2;
    localparam int ASC_B_SAMPLING_BIT = 1;
    localparam int ASC_B_DONE = 0;
    // Reference and buffer control fields.
    localparam int ASC_B_VCFG = 13;
    localparam int ASC_B_SCAN = 10;
    localparam int ASC_B_BUFFER_FILL_STATUS = 7;
    localparam int ASC_B_RATE = 2;
    localparam int ASC_B_BUFFER_MODE = 1;
    localparam int ASC_B_ALTERNATE_SAMPLE_MODE = 0;
    // Timing and channel fields.
    localparam int ASC_B_SAMC = 8;
    localparam int ASC_B_ADCS = 0;
    localparam int ASC_B_NEGB = 15;
    localparam int ASC_B_POSB = 8;
    localparam int ASC_B_NEGA = 7;
    localparam int ASC_B_POSA = 0;
    // Interrupt status bits.
    localparam int ASC_IRQ_RATE = 0;
    localparam int ASC_IRQ_CONV = 1;
    localparam int ASC_IRQ_W = 2;

    localparam logic [1:0] ASC_RESP_OKAY = 2'b00;
    localparam logic [1:0] ASC_RESP_SLVERR = 2'b10;
    localparam logic [3:0] ASC_HALF_B = 4'h8;

    typedef enum logic [2:0] {
        ASC_TRIG_MANUAL = 3'b000,
        ASC_TRIG_EXT = 3'b001,
        ASC_TRIG_TIMER = 3'b010,
        ASC_TRIG_AUTO = 3'b111
    } asc_trig_e;

    typedef enum logic [1:0] {
        ASC_FMT_INT = 2'b00,
        ASC_FMT_SINT = 2'b01,
        ASC_FMT_FRAC = 2'b10,
        ASC_FMT_SFRAC = 2'b11
    } asc_fmt_e;

    typedef enum logic [1:0] {
        ASC_ST_HOLD = 2'b00,
        ASC_ST_SAMPLE = 2'b01,
        ASC_ST_CONVERT = 2'b10
    } asc_state_e;
endpackage

// ==== sim/asc_core_model.sv ====
// Behavioural model of the analog sample/hold and conversion core.
`timescale 1ns/1ps
`default_nettype none
module asc_core_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic convStart,
    input wire logic [3:0] lat,
    input wire logic [9:0] code,
    output logic convDone,
    output logic [9:0] convResult
);
    logic [3:0] left;
    logic [9:0] held;
    // The input is held from the start pulse for lat cycles; lat must be at least 1.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            left <= 4'h0;
            held <= 10'h0;
        end else if (convStart) begin
            left <= lat;
            held <= code;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end
    end
    // Outside the done cycle the result lines carry junk, so a late read shows.
    assign convDone = (left == 4'h1);
    assign convResult = convDone ? held : ~held;
endmodule
`default_nettype wire

// ==== sim/asc_monitor.sv ====
// Port checker for the converter sequence control block.
`timescale 1ns/1ps
`default_nettype none
module asc_monitor (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic converterOn,
    input wire logic sampleHold,
    input wire logic convStart,
    input wire logic convClkTick
);
    // Every check lives in the one clock domain and is quiet during reset.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // A response must stand unchanged until the master takes it.
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped early");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped early");
    property p_ranswer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_ranswer: assert property (p_ranswer) else $error("read answer late");
    property p_rdrop;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_rdrop: assert property (p_rdrop) else $error("read answer repeated");
    property p_arrefuse;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_arrefuse: assert property (p_arrefuse) else $error("read taken while busy");
    // A converter that is off neither samples, converts nor clocks.
    property p_off;
        !converterOn |-> !sampleHold && !convStart && !convClkTick;
    endproperty
    a_off: assert property (p_off) else $error("activity while off");
    property p_hold;
        convStart |=> !sampleHold;
    endproperty
    a_hold: assert property (p_hold) else $error("still sampling after start");
    property p_cause;
        convStart |-> sampleHold && converterOn;
    endproperty
    a_cause: assert property (p_cause) else $error("start without sampling");
endmodule
bind asc_top asc_monitor asc_monitor_inst (
    .sys_clk, .rst_b, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .converterOn,
    .sampleHold, .convStart, .convClkTick
);
`default_nettype wire

// ==== sim/asc_tb_top.sv ====
// Self-checking bench for the converter sequence control block.
`timescale 1ns/1ps
`default_nettype none
module asc_tb_top;
    import asc_pkg::*;
    logic sys_clk = 1'b0, rst_b = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'h0, lat = 4'h1, chanPos;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, got;
    logic idleMode = 1'b0, timerCompareEvent = 1'b0, externalInterruptPin = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic converterOn, sampleHold, convStart, convClkTick, refPosExternal, refNegExternal;
    logic chanNegAlt, irq, convDone;
    logic [9:0] code = 10'h0, convResult;
    logic [2:0] srcs [3] = '{3'b010, 3'b001, 3'b110};
    int badCount = 0, numChecks = 0, seed = 87513, n;
    asc_top asc_top_inst (.sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .idleMode, .timerCompareEvent,
        .externalInterruptPin, .convDone, .convResult, .converterOn, .sampleHold, .convStart,
        .convClkTick, .refPosExternal, .refNegExternal, .chanPos, .chanNegAlt, .irq);
    asc_core_model asc_core_model_inst (.sys_clk, .rst_b, .convStart, .lat, .code, .convDone,
        .convResult);
    // Free-running system clock.
    initial forever #2.5 sys_clk = ~sys_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Handshakes are judged at the rising edge where both sides sample them.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic ga, gw, gb;
        gb = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0, d};
        s_axi_wstrb <= 4'h3;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int k = 0; k < 50 && !gb; k++) begin
            @(posedge sys_clk);
            ga = s_axi_awvalid && s_axi_awready;
            gw = s_axi_wvalid && s_axi_wready;
            gb = s_axi_bvalid && s_axi_bready;
            if (ga) s_axi_awvalid <= 1'b0;
            if (gw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        if (!gb) badCount++;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        logic ga, gr;
        gr = 1'b0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int k = 0; k < 50 && !gr; k++) begin
            @(posedge sys_clk);
            ga = s_axi_arvalid && s_axi_arready;
            gr = s_axi_rvalid && s_axi_rready;
            rv = s_axi_rdata;
            rs = s_axi_rresp;
            if (ga) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        if (!gr) badCount++;
        #1;
    endtask
    // One sample/convert sequence ended by the given trigger source.
    task automatic conv(input logic [2:0] src, input logic [1:0] f);
        code <= 10'($random(seed));
        lat <= 4'h1 + 4'($random(seed) & 7);
        // Turn on first: a sampling request is only heard once the module runs.
        wr(ASC_OFF_CTRL1, {1'b1, 5'h0, f, src, 5'h0});
        wr(ASC_OFF_CTRL1, {1'b1, 5'h0, f, src, 5'h2});
        if (src == 3'b000) begin
            wr(ASC_OFF_CTRL1, {1'b1, 5'h0, f, src, 5'h0});
        end else begin
            repeat (2) @(posedge sys_clk);
            timerCompareEvent <= (src != 3'b001);
            externalInterruptPin <= (src != 3'b010);
            @(posedge sys_clk);
            timerCompareEvent <= 1'b0;
            externalInterruptPin <= 1'b0;
        end
        got = 1'b0;
        for (int k = 0; k < 60 && !got; k++) begin
            @(negedge sys_clk);
            got = convDone;
        end
    endtask
    // Counts clock ticks over 40 cycles with the idle input at the given level.
    task automatic ticks(input logic idle);
        n = 0;
        @(posedge sys_clk);
        idleMode <= idle;
        repeat (2) @(posedge sys_clk);
        repeat (40) begin
            @(negedge sys_clk);
            n += convClkTick;
        end
    endtask
    function automatic logic [31:0] fmt_exp(input logic [1:0] f, input logic [9:0] r);
        case (f)
            2'b00: return {22'h0, r};
            2'b01: return {16'h0, {6{~r[9]}}, ~r[9], r[8:0]};
            2'b10: return {16'h0, r, 6'h0};
            default: return {16'h0, ~r[9], r[8:0], 6'h0};
        endcase
    endfunction
    task automatic testDone;
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Watchdog well beyond the expected run length.
    initial begin
        #200000;
        badCount++;
        testDone;
    end
    // Main sequence: reset values, triggers, formats, references, clocks, interrupts.
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(ASC_OFF_CTRL1);
        check(rv, 32'h0);
        rd(8'h30);
        check({rv[29:0], rs}, {30'h0, ASC_RESP_SLVERR});
        for (int i = 0; i < 3; i++) begin
            conv(srcs[i], 2'b00);
            check({31'h0, got}, {31'h0, i < 2});
            wr(ASC_OFF_CTRL1, 16'h0);
        end
        for (int f = 0; f < 4; f++) begin
            conv(3'b000, 2'(f));
            rd(ASC_OFF_CTRL1);
            check(rv, {16'h0, 1'b1, 5'h0, 2'(f), 8'h01});
            rd(8'h40);
            check(rv, fmt_exp(2'(f), code));
        end
        for (int v = 0; v < 8; v++) begin
            wr(ASC_OFF_CTRL2, {3'(v), 13'h0});
            check({30'h0, refPosExternal, refNegExternal},
                  {30'h0, v == 1 || v == 3, v == 2 || v == 3});
        end
        wr(ASC_OFF_CHSEL, 16'h0385);
        check(32'({chanNegAlt, chanPos}), 32'h15);
        wr(ASC_OFF_CTRL3, 16'h0003);
        wr(ASC_OFF_CTRL1, 16'h8000);
        ticks(1'b0);
        check(32'(n), 32'ha);
        ticks(1'b1);
        check(32'(n), 32'ha);
        wr(ASC_OFF_CTRL1, 16'ha000);
        ticks(1'b1);
        check(32'(n), 32'h0);
        ticks(1'b0);
        check(32'(n), 32'ha);
        wr(ASC_OFF_CTRL1, 16'h0);
        wr(ASC_OFF_IRQST, 16'h0003);
        wr(ASC_OFF_CTRL3, 16'h0100);
        wr(ASC_OFF_IRQMSK, 16'h0001);
        wr(ASC_OFF_CTRL2, 16'h0008);
        wr(ASC_OFF_CTRL1, 16'h80e4);
        n = 0;
        for (int k = 0; k < 3000 && irq !== 1'b1; k++) begin
            @(negedge sys_clk);
            n += convDone;
        end
        check(32'(n), 32'h3);
        wr(ASC_OFF_CTRL1, 16'h0);
        wr(ASC_OFF_IRQMSK, 16'h0);
        check({31'h0, irq}, 32'h0);
        rd(ASC_OFF_IRQST);
        check(rv, 32'h3);
        wr(ASC_OFF_IRQST, 16'h0003);
        rd(ASC_OFF_IRQST);
        check(rv, 32'h0);
        testDone;
    end
endmodule
`default_nettype wire
